//--- design/acfl_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "acfl_params.svh"

module acfl_top
    import acfl_pkg::*;
#(
    parameter int BLANK_CYCLES = `ACFL_BLANK_CYC,
    parameter int SAMPLE_W     = 16
)
(
    // Clock and reset
    input  wire logic                CLK_I,
    input  wire logic                RESET_N_I,
    // Management command port
    input  wire logic                CMD_VALID_I,
    input  wire logic                CMD_WRITE_I,
    input  wire logic [7:0]          CMD_CODE_I,
    input  wire logic [15:0]         CMD_DATA_I,
    input  wire logic                CLEAR_FAULTS_I,
    output logic [15:0]              RD_DATA_O,
    output logic                     RD_VALID_O,
    output logic                     WR_REJECT_O,
    // Strap and current sensing
    input  wire logic [6:0]          STRAP_PEAK_OC_A_I,
    input  wire logic                SLOPE_DOWN_I,
    input  wire logic                PWM_HIGH_I,
    input  wire logic                SAMPLE_VALID_I,
    input  wire logic [SAMPLE_W-1:0] SAMPLE_I,
    // Fault status and response triggers
    output logic                     OC_FAULT_O,
    output logic                     UC_FAULT_O,
    output logic                     OC_TRIP_O,
    output logic                     UC_TRIP_O,
    // Setup outputs
    output logic                     GATE_REGULATOR_OFF_O,
    output logic                     BUS_INPUT_LEVEL_SELECT_O,
    output logic                     PWM_MIDDLE_LEVEL_SELECT_O
);

    acfl_state_t        s_q;
    acfl_state_t        s_d;
    acfl_cmd_t          cmd;
    logic               rst_meta_q;
    logic               rst_n_q;
    logic signed [31:0] wr_fix;
    logic               wr_oc_ok;
    logic               wr_uc_ok;
    logic               in_interval;
    logic signed [55:0] oc_prod;
    logic signed [55:0] uc_prod;
    logic signed [55:0] sum_ext;
    logic [15:0]        def_man;
    logic [15:0]        def_oc_word;
    logic [15:0]        def_uc_word;
    logic signed [31:0] def_oc_fix;
    logic signed [31:0] def_uc_fix;

    // Reset release through two flip-flops
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Bundle the command port
    assign cmd = '{valid: CMD_VALID_I, write: CMD_WRITE_I, code: CMD_CODE_I, data: CMD_DATA_I};

    // Decode and range-check the incoming limit word
    acfl_l11_decode u_decode (
        .word_i  (cmd.valid & cmd.write),
        .l11_i   (cmd.data),
        .fix_o   (wr_fix),
        .oc_ok_o (wr_oc_ok),
        .uc_ok_o (wr_uc_ok)
    );

    // Default limits from the strap, exponent -3
    assign def_man     = 16'((32'(STRAP_PEAK_OC_A_I) * `ACFL_DEF_NUM + `ACFL_DEF_DEN / 2) / `ACFL_DEF_DEN);
    assign def_oc_word = {`ACFL_DEF_EXP, def_man[10:0]};
    assign def_uc_word = {`ACFL_DEF_EXP, 11'(-def_man)};
    assign def_oc_fix  = 32'(def_man) <<< 1;
    assign def_uc_fix  = -(32'(def_man) <<< 1);

    // Sensed interval follows the selected slope
    assign in_interval = SLOPE_DOWN_I ? ~PWM_HIGH_I : PWM_HIGH_I;

    // Average above or below a limit, compared without dividing
    assign sum_ext = 56'(s_q.sum);
    assign oc_prod = 56'(s_q.oc_fix) * $signed({40'h0, s_q.cnt});
    assign uc_prod = 56'(s_q.uc_fix) * $signed({40'h0, s_q.cnt});

    // Next-state logic
    always_comb
    begin
        s_d           = s_q;
        s_d.oc_trip   = 1'b0;
        s_d.uc_trip   = 1'b0;
        s_d.rd_valid  = 1'b0;
        s_d.wr_reject = 1'b0;

        // Catch the strap once after reset release
        if (!s_q.init_done)
        begin
            s_d.init_done = 1'b1;
            s_d.oc_word   = def_oc_word;
            s_d.oc_fix    = def_oc_fix;
            s_d.uc_word   = def_uc_word;
            s_d.uc_fix    = def_uc_fix;
        end

        // Register writes and reads
        if (cmd.valid && cmd.write)
        begin
            unique case (cmd.code)
                `ACFL_CMD_AVG_OC:
                begin
                    if (wr_oc_ok)
                    begin
                        s_d.oc_word = cmd.data;
                        s_d.oc_fix  = wr_fix;
                    end
                    else
                    begin
                        s_d.wr_reject = 1'b1;
                    end
                end
                `ACFL_CMD_AVG_UC:
                begin
                    if (wr_uc_ok)
                    begin
                        s_d.uc_word = cmd.data;
                        s_d.uc_fix  = wr_fix;
                    end
                    else
                    begin
                        s_d.wr_reject = 1'b1;
                    end
                end
                `ACFL_CMD_SETUP:
                begin
                    s_d.setup = cmd.data[7:0] & `ACFL_SETUP_WMASK;
                end
                default:
                begin
                    s_d.wr_reject = 1'b1;
                end
            endcase
        end
        else if (cmd.valid)
        begin
            s_d.rd_valid = 1'b1;
            unique case (cmd.code)
                `ACFL_CMD_AVG_OC: s_d.rd_data = s_q.oc_word;
                `ACFL_CMD_AVG_UC: s_d.rd_data = s_q.uc_word;
                `ACFL_CMD_SETUP:  s_d.rd_data = {8'h00, s_q.setup};
                default:          s_d.rd_data = 16'h0000;
            endcase
        end

        // Sampling sequence over one switching period
        unique case (s_q.phase)
            ACFL_IDLE:
            begin
                if (in_interval)
                begin
                    s_d.sum       = '0;
                    s_d.cnt       = '0;
                    s_d.blank_cnt = 8'(BLANK_CYCLES - 1);
                    s_d.phase     = ACFL_BLANK;
                end
            end
            ACFL_BLANK:
            begin
                if (!in_interval)
                begin
                    s_d.phase = ACFL_IDLE;
                end
                else if (s_q.blank_cnt == 8'h00)
                begin
                    s_d.phase = ACFL_SUM;
                end
                else
                begin
                    s_d.blank_cnt = s_q.blank_cnt - 8'h01;
                end
            end
            ACFL_SUM:
            begin
                if (!in_interval)
                begin
                    s_d.phase = ACFL_IDLE;
                    if (s_q.cnt != 16'h0000)
                    begin
                        s_d.oc_trip = (sum_ext > oc_prod);
                        s_d.uc_trip = (sum_ext < uc_prod);
                    end
                end
                else if (SAMPLE_VALID_I && s_q.cnt != 16'hffff)
                begin
                    s_d.sum = s_q.sum + 40'($signed(SAMPLE_I));
                    s_d.cnt = s_q.cnt + 16'h0001;
                end
            end
        endcase

        // Sticky flags, a new trip wins over the clear
        if (CLEAR_FAULTS_I)
        begin
            s_d.oc_flag = 1'b0;
            s_d.uc_flag = 1'b0;
        end
        if (s_d.oc_trip)
        begin
            s_d.oc_flag = 1'b1;
        end
        if (s_d.uc_trip)
        begin
            s_d.uc_flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge CLK_I or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            s_q           <= '0;
            s_q.setup     <= `ACFL_SETUP_RESET;
            s_q.phase     <= ACFL_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign RD_DATA_O                 = s_q.rd_data;
    assign RD_VALID_O                = s_q.rd_valid;
    assign WR_REJECT_O               = s_q.wr_reject;
    assign OC_FAULT_O                = s_q.oc_flag;
    assign UC_FAULT_O                = s_q.uc_flag;
    assign OC_TRIP_O                 = s_q.oc_trip;
    assign UC_TRIP_O                 = s_q.uc_trip;
    assign GATE_REGULATOR_OFF_O      = s_q.setup[`ACFL_SETUP_GATE];
    assign BUS_INPUT_LEVEL_SELECT_O  = s_q.setup[`ACFL_SETUP_BUSLVL];
    assign PWM_MIDDLE_LEVEL_SELECT_O = s_q.setup[`ACFL_SETUP_MID];

endmodule
`default_nettype wire

//--- include/acfl_params.svh
`ifndef ACFL_PARAMS_SVH
`define ACFL_PARAMS_SVH

// Command codes of the three registers
`define ACFL_CMD_AVG_OC   8'he7
`define ACFL_CMD_AVG_UC   8'he8
`define ACFL_CMD_SETUP    8'he9

// Linear-11 field positions
`define ACFL_L11_EXP_HI   15
`define ACFL_L11_EXP_LO   11
`define ACFL_L11_MAN_HI   10
`define ACFL_L11_MAN_LO   0

// Setup byte layout and reset value
`define ACFL_SETUP_RESET  8'h01
`define ACFL_SETUP_WMASK  8'h07
`define ACFL_SETUP_GATE   2
`define ACFL_SETUP_BUSLVL 1
`define ACFL_SETUP_MID    0

// Fixed-point current: fraction bits, span limits in amperes
`define ACFL_FRAC_BITS    4
`define ACFL_OC_MAX_A     100
`define ACFL_UC_MIN_A     100

// Default limits as 0.8 times strap: exponent -3, mantissa 6.4 x amperes
`define ACFL_DEF_EXP      5'h1d
`define ACFL_DEF_NUM      64
`define ACFL_DEF_DEN      10

// Blanking time and clock period
`define ACFL_BLANK_NS     100
`define ACFL_CLK_NS       20
`define ACFL_BLANK_CYC    ((`ACFL_BLANK_NS + `ACFL_CLK_NS - 1) / `ACFL_CLK_NS)

`endif

//--- include/acfl_pkg.sv
package acfl_pkg;

    // Host command port request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } acfl_cmd_t;

    // Sampling phase of one switching period
    typedef enum logic [2:0] {
        ACFL_IDLE  = 3'b001,
        ACFL_BLANK = 3'b010,
        ACFL_SUM   = 3'b100
    } acfl_phase_t;

    // Whole state of the top module apart from the two reset synchronizer flip-flops
    typedef struct packed {
        logic               init_done;
        logic [15:0]        oc_word;
        logic [15:0]        uc_word;
        logic signed [31:0] oc_fix;
        logic signed [31:0] uc_fix;
        logic [7:0]         setup;
        acfl_phase_t        phase;
        logic [7:0]         blank_cnt;
        logic signed [39:0] sum;
        logic [15:0]        cnt;
        logic               oc_flag;
        logic               uc_flag;
        logic               oc_trip;
        logic               uc_trip;
        logic [15:0]        rd_data;
        logic               rd_valid;
        logic               wr_reject;
    } acfl_state_t;

endpackage

//--- design/acfl_l11_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "acfl_params.svh"

module acfl_l11_decode
    import acfl_pkg::*;
(
    // Linear-11 word in
    input  wire logic        word_i,
    input  wire logic [15:0] l11_i,
    // Fixed-point value and span checks
    output logic signed [31:0] fix_o,
    output logic               oc_ok_o,
    output logic               uc_ok_o
);

    logic signed [4:0]  exp_s;
    logic signed [10:0] man_s;
    logic signed [6:0]  shift_s;
    logic               ovf;

    // Split the word into exponent and mantissa
    assign exp_s = $signed(l11_i[`ACFL_L11_EXP_HI:`ACFL_L11_EXP_LO]);
    assign man_s = $signed(l11_i[`ACFL_L11_MAN_HI:`ACFL_L11_MAN_LO]);
    assign shift_s = 7'(exp_s) + 7'(`ACFL_FRAC_BITS);

    // Scale mantissa by two to the exponent into fixed point
    always_comb
    begin
        ovf   = 1'b0;
        fix_o = 32'(man_s);
        if (shift_s >= 7'sd0)
        begin
            if (shift_s > 7'sd16 && man_s != 11'sd0)
            begin
                ovf = 1'b1;
            end
            else
            begin
                fix_o = 32'(man_s) <<< shift_s[4:0];
            end
        end
        else
        begin
            fix_o = 32'(man_s) >>> 5'(-shift_s);
        end
    end

    // Accept only values inside each limit's span
    assign oc_ok_o = word_i & ~ovf & (fix_o >= 0) &
                     (fix_o <= (`ACFL_OC_MAX_A <<< `ACFL_FRAC_BITS));
    assign uc_ok_o = word_i & ~ovf & (fix_o <= 0) &
                     (fix_o >= -(`ACFL_UC_MIN_A <<< `ACFL_FRAC_BITS));

endmodule
`default_nettype wire

//--- verif/acfl_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module acfl_monitor
    import acfl_pkg::*;
#(
    parameter int BLANK_CYCLES = 5
)
(
    // Clock and reset
    input wire logic        CLK_I,
    input wire logic        RESET_N_I,
    // Command port
    input wire logic        CMD_VALID_I,
    input wire logic        CMD_WRITE_I,
    input wire logic [7:0]  CMD_CODE_I,
    input wire logic [15:0] CMD_DATA_I,
    input wire logic        CLEAR_FAULTS_I,
    input wire logic [15:0] RD_DATA_O,
    input wire logic        RD_VALID_O,
    input wire logic        WR_REJECT_O,
    // Sensing and faults
    input wire logic        SLOPE_DOWN_I,
    input wire logic        PWM_HIGH_I,
    input wire logic        OC_FAULT_O,
    input wire logic        UC_FAULT_O,
    input wire logic        OC_TRIP_O,
    input wire logic        UC_TRIP_O,
    // Setup outputs
    input wire logic        GATE_REGULATOR_OFF_O,
    input wire logic        BUS_INPUT_LEVEL_SELECT_O,
    input wire logic        PWM_MIDDLE_LEVEL_SELECT_O
);
    logic [2:0] age_q;
    wire logic  iv = SLOPE_DOWN_I ? !PWM_HIGH_I : PWM_HIGH_I;
    wire logic  cw = CMD_VALID_I && CMD_WRITE_I && age_q == 3'h4;
    wire logic  sw = cw && CMD_CODE_I == 8'he9;

    // Edges since reset release; writes in the init cycles are ignored
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            age_q <= 3'h0;
        else if (age_q != 3'h4)
            age_q <= age_q + 3'h1;
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    property p_mask;
        RD_VALID_O && $past(CMD_CODE_I) == 8'he9 |-> RD_DATA_O[15:3] == 13'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("setup high bits set");
    property p_setup;
        sw |=> {GATE_REGULATOR_OFF_O, BUS_INPUT_LEVEL_SELECT_O, PWM_MIDDLE_LEVEL_SELECT_O} == $past(CMD_DATA_I[2:0]);
    endproperty
    a_setup: assert property (p_setup) else $error("setup outputs wrong");
    property p_oc_rej;
        cw && CMD_CODE_I == 8'he7 && CMD_DATA_I[15:10] == 6'h01 |=> WR_REJECT_O;
    endproperty
    a_oc_rej: assert property (p_oc_rej) else $error("negative limit kept");
    property p_uc_rej;
        cw && CMD_CODE_I == 8'he8 && CMD_DATA_I[15:10] == 6'h0 && CMD_DATA_I[9:0] != 10'h0 |=> WR_REJECT_O;
    endproperty
    a_uc_rej: assert property (p_uc_rej) else $error("positive limit kept");
    property p_oc_hold;
        $fell(OC_FAULT_O) |-> $past(CLEAR_FAULTS_I);
    endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("oc flag dropped");
    property p_uc_hold;
        $fell(UC_FAULT_O) |-> $past(CLEAR_FAULTS_I);
    endproperty
    a_uc_hold: assert property (p_uc_hold) else $error("uc flag dropped");
    property p_oc_trip;
        OC_TRIP_O |-> OC_FAULT_O ##1 !OC_TRIP_O;
    endproperty
    a_oc_trip: assert property (p_oc_trip) else $error("oc trip wrong");
    property p_uc_trip;
        UC_TRIP_O |-> UC_FAULT_O ##1 !UC_TRIP_O;
    endproperty
    a_uc_trip: assert property (p_uc_trip) else $error("uc trip wrong");
    property p_close;
        OC_TRIP_O || UC_TRIP_O |-> !$past(iv) && $past(iv, 2) && $past(iv, BLANK_CYCLES + 3);
    endproperty
    a_close: assert property (p_close) else $error("trip off interval end");
endmodule

bind acfl_top acfl_monitor #(.BLANK_CYCLES(BLANK_CYCLES)) u_mon (.CLK_I, .RESET_N_I, .CMD_VALID_I, .CMD_WRITE_I,
    .CMD_CODE_I, .CMD_DATA_I, .CLEAR_FAULTS_I, .RD_DATA_O, .RD_VALID_O, .WR_REJECT_O, .SLOPE_DOWN_I, .PWM_HIGH_I,
    .OC_FAULT_O, .UC_FAULT_O, .OC_TRIP_O, .UC_TRIP_O, .GATE_REGULATOR_OFF_O, .BUS_INPUT_LEVEL_SELECT_O,
    .PWM_MIDDLE_LEVEL_SELECT_O);

`default_nettype wire

//--- verif/acfl_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module acfl_host_model
(
    // Clock
    input  wire logic        clk_i,
    // Command port
    output logic             valid_o,
    output logic             write_o,
    output logic [7:0]       code_o,
    output logic [15:0]      data_o,
    // Answers
    input  wire logic [15:0] rd_data_i,
    input  wire logic        rd_valid_i,
    input  wire logic        wr_reject_i
);
    // Linear-11 word: exponent on top, mantissa below
    function automatic logic [15:0] l11(input logic [4:0] n, input logic [10:0] y);
        return {n, y};
    endfunction

    // Idle port at time zero
    initial
    begin
        valid_o = 1'b0;
        write_o = 1'b0;
        code_o  = 8'h00;
        data_o  = 16'h0000;
    end

    // One command; released code and data lines show inverted values
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [17:0] a);
        @(negedge clk_i);
        valid_o = 1'b1;
        write_o = w;
        code_o  = c;
        data_o  = d;
        @(negedge clk_i);
        a       = {rd_valid_i, wr_reject_i, rd_data_i};
        valid_o = 1'b0;
        code_o  = ~c;
        data_o  = ~d;
    endtask
endmodule

`default_nettype wire

//--- verif/avg_current_fault_limits_test.sv
`timescale 1ns/100ps
`default_nettype none

module avg_current_fault_limits_test
    import acfl_pkg::*;
;
    localparam int BLANK = 2;
    logic        clk, rst_n, clr, slope, pwm, sval, cv, cw, rv, rj, ocf, ucf, oct, uct, gate, bus, mid, eoc, euc;
    logic [7:0]  cc;
    logic [6:0]  strap;
    logic [15:0] cd, rdd, smp;
    int          errors, samples_checked;

    acfl_top #(.BLANK_CYCLES(BLANK), .SAMPLE_W(16)) u_dut (.CLK_I(clk), .RESET_N_I(rst_n), .CMD_VALID_I(cv),
        .CMD_WRITE_I(cw), .CMD_CODE_I(cc), .CMD_DATA_I(cd), .CLEAR_FAULTS_I(clr), .RD_DATA_O(rdd),
        .RD_VALID_O(rv), .WR_REJECT_O(rj), .STRAP_PEAK_OC_A_I(strap), .SLOPE_DOWN_I(slope), .PWM_HIGH_I(pwm),
        .SAMPLE_VALID_I(sval), .SAMPLE_I(smp), .OC_FAULT_O(ocf), .UC_FAULT_O(ucf), .OC_TRIP_O(oct),
        .UC_TRIP_O(uct), .GATE_REGULATOR_OFF_O(gate), .BUS_INPUT_LEVEL_SELECT_O(bus),
        .PWM_MIDDLE_LEVEL_SELECT_O(mid));
    acfl_host_model u_host (.clk_i(clk), .valid_o(cv), .write_o(cw), .code_o(cc), .data_o(cd),
        .rd_data_i(rdd), .rd_valid_i(rv), .wr_reject_i(rj));

    // Clock of 20 ns
    always #10 clk = ~clk;

    task automatic chk(input logic [17:0] a, input logic [17:0] e);
        samples_checked++;
        if (a !== e)
            $display("Error at %0t: got %h expected %h", $time, a, e);
        if (a !== e)
            errors++;
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        logic [17:0] a;
        u_host.xfer(1'b0, c, 16'h0000, a);
        chk(a, {2'b10, e});
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic r);
        logic [17:0] a;
        u_host.xfer(1'b1, c, d, a);
        chk({a[17:16], 16'h0}, {1'b0, r, 16'h0});
    endtask

    // One interval: blank-time samples, then summed samples, then close
    task automatic per(input logic s, input logic [15:0] bv, input logic [15:0] v, input logic eo, input logic eu);
        @(negedge clk);
        slope = s;
        pwm   = ~s;
        sval  = 1'b1;
        smp   = bv;
        repeat (BLANK + 1) @(negedge clk);
        smp = v;
        repeat (4) @(negedge clk);
        pwm  = s;
        sval = 1'b0;
        smp  = ~v;
        @(negedge clk);
        eoc = eoc | eo;
        euc = euc | eu;
        chk({14'h0, oct, uct, ocf, ucf}, {14'h0, eo, eu, eoc, euc});
    endtask

    task automatic clear;
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        eoc = 1'b0;
        euc = 1'b0;
        chk({16'h0, ocf, ucf}, 18'h0);
    endtask

    task automatic test_done;
        $display("Compared %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done();
    end

    // Main sequence
    initial
    begin
        {clk, rst_n, clr, slope, pwm, sval, eoc, euc} = 8'h00;
        smp             = 16'h0000;
        strap           = 7'h0a;
        errors          = 0;
        samples_checked = 0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({15'h0, gate, bus, mid}, 18'h1);
        rd(8'he7, 16'he840);
        rd(8'he8, 16'hefc0);
        rd(8'he9, 16'h0001);
        wr(8'he9, 16'h00ff, 1'b0);
        rd(8'he9, 16'h0007);
        chk({15'h0, gate, bus, mid}, 18'h7);
        wr(8'he9, 16'h0002, 1'b0);
        chk({15'h0, gate, bus, mid}, 18'h2);
        rd(8'hea, 16'h0000);
        wr(8'hea, 16'h0001, 1'b1);
        wr(8'he7, 16'h07ff, 1'b1);
        wr(8'he7, 16'h0065, 1'b1);
        wr(8'he8, 16'h0001, 1'b1);
        wr(8'he8, 16'h079b, 1'b1);
        rd(8'he7, 16'he840);
        rd(8'he8, 16'hefc0);
        wr(8'he7, 16'h0064, 1'b0);
        rd(8'he7, 16'h0064);
        wr(8'he8, 16'h079c, 1'b0);
        rd(8'he8, 16'h079c);
        wr(8'he7, u_host.l11(5'h1f, 11'h004), 1'b0);
        wr(8'he8, u_host.l11(5'h01, 11'h7ff), 1'b0);
        per(1'b0, 16'h0100, 16'h0010, 1'b0, 1'b0);
        per(1'b0, 16'h0010, 16'h0020, 1'b0, 1'b0);
        per(1'b0, 16'h0010, 16'h0030, 1'b1, 1'b0);
        per(1'b1, 16'hff00, 16'h0010, 1'b0, 1'b0);
        clear();
        per(1'b1, 16'h0010, 16'hffd0, 1'b0, 1'b1);
        clear();
        // Mid-run reset with a new strap: defaults follow it, setup returns to 01h
        @(negedge clk);
        rst_n = 1'b0;
        strap = 7'h64;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({15'h0, gate, bus, mid}, 18'h1);
        rd(8'he7, 16'hea80);
        rd(8'he8, 16'hed80);
        // 81 A against the 80 A default limits, both signs
        per(1'b1, 16'h0000, 16'h0510, 1'b1, 1'b0);
        per(1'b1, 16'h0000, 16'hfaf0, 1'b0, 1'b1);
        test_done();
    end
endmodule

`default_nettype wire
